// file: verilog/dpll_reference_profile_bank.sv
// Register bank for one reference profile of the digital PLL.
// Assumes an Avalon-MM master that holds its request until waitrequest is low.
// What this block does
// - Three-bit selection priority in bits two to zero
// - Promoted priority applies while reference is active
// - Scale bit zero means phase threshold picoseconds
// - Scale bit one means phase threshold nanoseconds
// - Fifty-bit reference period, low byte first
// - Twenty-bit inner tolerance, top nibble unused
// - Twenty-bit outer tolerance, top nibble unused
// - Sixteen-bit validation timer, milliseconds, low first
// - Sixteen-bit redetect timer, milliseconds, low first
// - Coefficient is fraction times power of two
// - Alpha has linear and three exponent fields
// - Beta, gamma, delta linear parts with exponents
// - Input divider thirty bits, divides by value+1
// - Feedback integer thirty bits, divides by value+1
// - Fractional feedback holds two ten-bit terms
// - Phase lock threshold, fill and drain rates
// - Frequency lock threshold, fill and drain rates
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps

module dpll_reference_profile_bank #(
    parameter int ADDR_W = 13
) (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic [ADDR_W-1:0]           address,
    input  wire logic                        read,
    input  wire logic                        write,
    input  wire logic [31:0]                 writedata,
    input  wire logic [3:0]                  byteenable,
    output logic      [31:0]                 readdata,
    output logic                             waitrequest,
    input  wire logic                        refActive,
    output profile_bank_pkg::profile_s       profile,
    output profile_bank_pkg::derived_s       derived
);

    // Address must reach the status register
    if (ADDR_W < profile_bank_pkg::ADDR_W_MIN) begin : g_check
        $error("ADDR_W too small for the register map");
    end

    typedef struct packed {
        profile_bank_pkg::byte_file_t regs;
        logic                         ack;
        logic [7:0]                   rdata;
        profile_bank_pkg::derived_s   der;
    } state_s;

    state_s state_q;
    state_s state_d;

    logic [10:0] idx;
    logic [10:0] rel;
    logic        inStore;
    logic        isStatus;
    logic [7:0]  statusByte;
    profile_bank_pkg::profile_s prof;
    profile_bank_pkg::profile_s profNext;

    // Writable bits of a stored byte; the rest hold zero
    function automatic logic [7:0] byte_mask(input logic [10:0] i);
        case (i)
            profile_bank_pkg::IDX_PRIORITIES:        byte_mask = profile_bank_pkg::MASK_PRIORITIES;
            11'h639:                                 byte_mask = profile_bank_pkg::MASK_LOW2;
            11'h63c:                                 byte_mask = profile_bank_pkg::MASK_LOW4;
            11'h63f:                                 byte_mask = profile_bank_pkg::MASK_LOW4;
            11'h649:                                 byte_mask = profile_bank_pkg::MASK_LOW7;
            11'h64c:                                 byte_mask = profile_bank_pkg::MASK_LOW6;
            11'h653:                                 byte_mask = profile_bank_pkg::MASK_LOW6;
            11'h657:                                 byte_mask = profile_bank_pkg::MASK_LOW6;
            11'h659:                                 byte_mask = profile_bank_pkg::MASK_FRAC_MID;
            11'h65a:                                 byte_mask = profile_bank_pkg::MASK_LOW6;
            default:                                 byte_mask = profile_bank_pkg::MASK_FULL;
        endcase
    endfunction

    // Gather the settings fields out of the byte file
    function automatic profile_bank_pkg::profile_s unpack(input profile_bank_pkg::byte_file_t b);
        profile_bank_pkg::profile_s p;
        p.selPriority      = b[0][profile_bank_pkg::PRI_SEL_LSB +: 3];
        p.promotedPriority = b[0][profile_bank_pkg::PRI_PROMO_LSB +: 3];
        p.phaseScaleNs     = b[0][profile_bank_pkg::PRI_SCALE_BIT];
        p.refPeriodFs      = {b[7][1:0], b[6], b[5], b[4], b[3], b[2], b[1]};
        p.innerTolerance   = {b[10][3:0], b[9], b[8]};
        p.outerTolerance   = {b[13][3:0], b[12], b[11]};
        p.validationMs     = {b[15], b[14]};
        p.redetectMs       = {b[17], b[16]};
        // Linear parts are fractions below one, exponents are integers
        p.alphaLinear      = {b[19], b[18]};
        p.alphaExp1        = b[20][5:0];
        p.alphaExp2        = {b[21][0], b[20][7:6]};
        p.alphaExp3        = b[29][7:4];
        p.betaLinear       = {b[23][1:0], b[22], b[21][7:1]};
        p.betaExp          = b[23][6:2];
        p.gammaLinear      = {b[26][0], b[25], b[24]};
        p.gammaExp         = b[26][5:1];
        p.deltaLinear      = {b[28][6:0], b[27]};
        p.deltaExp         = {b[29][3:0], b[28][7]};
        p.inDivide         = {b[33][5:0], b[32], b[31], b[30]};
        p.fbInteger        = {b[37][5:0], b[36], b[35], b[34]};
        p.fbFracV          = {b[39][1:0], b[38]};
        p.fbFracU          = {b[40][5:0], b[39][7:4]};
        p.phaseThreshold   = {b[42], b[41]};
        p.phaseFill        = b[43];
        p.phaseDrain       = b[44];
        p.freqThresholdPs  = {b[47], b[46], b[45]};
        p.freqFill         = b[48];
        p.freqDrain        = b[49];
        return p;
    endfunction

    // Address decode
    assign idx      = address[12:2];
    assign rel      = idx - profile_bank_pkg::IDX_FIRST;
    assign inStore  = (idx >= profile_bank_pkg::IDX_FIRST) &&
                      (idx <= profile_bank_pkg::IDX_LAST_USED);
    assign isStatus = (idx == profile_bank_pkg::IDX_STATUS);
    assign prof     = unpack(state_q.regs);

    // Read-only status: programming faults and the active flag
    always_comb begin
        statusByte = 8'h00;
        statusByte[profile_bank_pkg::STAT_PRIO_BAD] =
            prof.promotedPriority > prof.selPriority;
        statusByte[profile_bank_pkg::STAT_FB_LOW] =
            prof.fbInteger < profile_bank_pkg::FB_INT_MIN;
        statusByte[profile_bank_pkg::STAT_ACTIVE] = refActive;
    end

    // Next state: bus handshake, byte writes and derived values
    always_comb begin
        state_d  = state_q;
        profNext = prof;
        state_d.ack = (read | write) & ~state_q.ack;
        // Read data is captured while waitrequest is high
        if (read && !state_q.ack) begin
            if (inStore) begin
                state_d.rdata = state_q.regs[rel[5:0]];
            end else if (isStatus) begin
                state_d.rdata = statusByte;
            end else begin
                state_d.rdata = 8'h00;
            end
        end
        // Write takes effect at the edge with waitrequest low
        if (write && state_q.ack && byteenable[0] && inStore) begin
            state_d.regs[rel[5:0]] = writedata[7:0] & byte_mask(idx);
        end
        profNext = unpack(state_d.regs);
        // Promoted level replaces selection level only while active
        state_d.der.effPriority = refActive ? profNext.promotedPriority
                                            : profNext.selPriority;
        state_d.der.inDivideRatio = {1'b0, profNext.inDivide} + 31'h1;
        state_d.der.fbDivideRatio = {1'b0, profNext.fbInteger} + 31'h1;
        // Threshold normalised to picoseconds per the scale bit
        if (profNext.phaseScaleNs) begin
            state_d.der.phaseThresholdPs =
                26'({10'h000, profNext.phaseThreshold} * profile_bank_pkg::PS_PER_NS);
        end else begin
            state_d.der.phaseThresholdPs = {10'h000, profNext.phaseThreshold};
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q       <= '0;
            state_q.der.inDivideRatio <= 31'h1;
            state_q.der.fbDivideRatio <= 31'h1;
        end else begin
            state_q <= state_d;
        end
    end

    // Bus and settings outputs
    assign waitrequest = (read | write) & ~state_q.ack;
    assign readdata    = {24'h000000, state_q.rdata};
    assign profile     = prof;
    assign derived     = state_q.der;

endmodule

// file: verilog/profile_bank_pkg.sv
// Constants and carrier types for the reference profile register bank.
// Assumes an Avalon-MM slave with 32-bit data and one byte register per word.
package profile_bank_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [10:0] IDX_FIRST     = 11'h632;
    localparam logic [10:0] IDX_LAST_USED = 11'h663;
    localparam logic [10:0] IDX_LAST      = 11'h67f;
    localparam logic [10:0] IDX_STATUS    = 11'h700;
    localparam int          NUM_BYTES     = 50;
    localparam int          ADDR_W_MIN    = 13;

    // Register indices of the first byte of each setting
    localparam logic [10:0] IDX_PRIORITIES  = 11'h632;
    localparam logic [10:0] IDX_REF_PERIOD  = 11'h633;
    localparam logic [10:0] IDX_INNER_TOL   = 11'h63a;
    localparam logic [10:0] IDX_OUTER_TOL   = 11'h63d;
    localparam logic [10:0] IDX_VALID_TMR   = 11'h640;
    localparam logic [10:0] IDX_REDET_TMR   = 11'h642;
    localparam logic [10:0] IDX_LOOP_COEF   = 11'h644;
    localparam logic [10:0] IDX_IN_DIV      = 11'h650;
    localparam logic [10:0] IDX_FB_INT      = 11'h654;
    localparam logic [10:0] IDX_FB_FRAC     = 11'h658;
    localparam logic [10:0] IDX_PH_THRESH   = 11'h65b;
    localparam logic [10:0] IDX_PH_FILL     = 11'h65d;
    localparam logic [10:0] IDX_PH_DRAIN    = 11'h65e;
    localparam logic [10:0] IDX_FR_THRESH   = 11'h65f;
    localparam logic [10:0] IDX_FR_FILL     = 11'h662;
    localparam logic [10:0] IDX_FR_DRAIN    = 11'h663;

    // Writable bit masks of the full and the partly used bytes
    localparam logic [7:0] MASK_FULL       = 8'hff;
    localparam logic [7:0] MASK_PRIORITIES = 8'hbf;
    localparam logic [7:0] MASK_LOW2       = 8'h03;
    localparam logic [7:0] MASK_LOW4       = 8'h0f;
    localparam logic [7:0] MASK_LOW6       = 8'h3f;
    localparam logic [7:0] MASK_LOW7       = 8'h7f;
    localparam logic [7:0] MASK_FRAC_MID   = 8'hf3;

    // Field positions in the priorities byte
    localparam int PRI_SCALE_BIT = 7;
    localparam int PRI_PROMO_LSB = 3;
    localparam int PRI_SEL_LSB   = 0;

    // Reset values, limits and the nanosecond scale factor
    localparam logic [7:0]  RESET_BYTE     = 8'h00;
    localparam logic [29:0] FB_INT_MIN     = 30'h0000_0007;
    localparam logic [25:0] PS_PER_NS      = 26'h00003e8;

    // Status bit positions
    localparam int STAT_PRIO_BAD = 0;
    localparam int STAT_FB_LOW   = 1;
    localparam int STAT_ACTIVE   = 2;

    typedef logic [NUM_BYTES-1:0][7:0] byte_file_t;

    // Decoded profile settings
    typedef struct packed {
        logic [2:0]  selPriority;
        logic [2:0]  promotedPriority;
        logic        phaseScaleNs;
        logic [49:0] refPeriodFs;
        logic [19:0] innerTolerance;
        logic [19:0] outerTolerance;
        logic [15:0] validationMs;
        logic [15:0] redetectMs;
        logic [15:0] alphaLinear;
        logic [5:0]  alphaExp1;
        logic [2:0]  alphaExp2;
        logic [3:0]  alphaExp3;
        logic [16:0] betaLinear;
        logic [4:0]  betaExp;
        logic [16:0] gammaLinear;
        logic [4:0]  gammaExp;
        logic [14:0] deltaLinear;
        logic [4:0]  deltaExp;
        logic [29:0] inDivide;
        logic [29:0] fbInteger;
        logic [9:0]  fbFracV;
        logic [9:0]  fbFracU;
        logic [15:0] phaseThreshold;
        logic [7:0]  phaseFill;
        logic [7:0]  phaseDrain;
        logic [23:0] freqThresholdPs;
        logic [7:0]  freqFill;
        logic [7:0]  freqDrain;
    } profile_s;

    // Values derived for the consuming logic
    typedef struct packed {
        logic [2:0]  effPriority;
        logic [30:0] inDivideRatio;
        logic [30:0] fbDivideRatio;
        logic [25:0] phaseThresholdPs;
    } derived_s;

endpackage

// file: tb/profile_bank_sva.sv
// Port-level checks for the reference profile register bank.
// Bound into every instance of the bank; sees its ports only.
`timescale 1ns/1ps
module profile_bank_sva #(
    parameter int ADDR_W = 13
) (
    input wire logic                       clk,
    input wire logic                       nrst,
    input wire logic [ADDR_W-1:0]          address,
    input wire logic                       read,
    input wire logic                       write,
    input wire logic [31:0]                writedata,
    input wire logic [3:0]                 byteenable,
    input wire logic [31:0]                readdata,
    input wire logic                       waitrequest,
    input wire logic                       refActive,
    input wire profile_bank_pkg::profile_s profile,
    input wire profile_bank_pkg::derived_s derived
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // Completed read and its word index
    wire        rdDone = read && !waitrequest;
    wire [10:0] idx    = address[12:2];
    // The two phases of one bus access
    sequence accReq;
        (read || write) && waitrequest;
    endsequence
    sequence accDone;
        (read || write) && !waitrequest;
    endsequence
    chk_ack_next: assert property (accReq |=> accDone)
        else $error("request not answered on the next cycle");
    chk_idle_nowait: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest high with no request");
    chk_rd_upper: assert property (rdDone |-> readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_rd_prio: assert property (rdDone && idx == profile_bank_pkg::IDX_PRIORITIES |->
        readdata[7:0] == {profile.phaseScaleNs, 1'h0, profile.promotedPriority,
        profile.selPriority}) else $error("priorities byte differs from its fields");
    chk_unmapped_zero: assert property (rdDone && idx > 11'h663 && idx <= 11'h67f |->
        readdata == 32'h0) else $error("unused address read not zero");
    chk_hold_prof: assert property (!(write && !waitrequest && byteenable[0]) |=>
        $stable(profile)) else $error("settings changed without a write");
    // Derived values register together with the bytes they come from
    chk_in_ratio: assert property (derived.inDivideRatio ==
        {1'b0, profile.inDivide} + 31'h1) else $error("input ratio not value plus one");
    chk_fb_ratio: assert property (derived.fbDivideRatio ==
        {1'b0, profile.fbInteger} + 31'h1) else $error("feedback ratio not value plus one");
    chk_eff_prio: assert property (derived.effPriority == ($past(refActive) ?
        profile.promotedPriority : profile.selPriority))
        else $error("effective priority wrong");
    chk_phase_ps: assert property (derived.phaseThresholdPs == (profile.phaseScaleNs ?
        26'(profile.phaseThreshold) * 26'h3e8 : 26'(profile.phaseThreshold)))
        else $error("phase threshold scaling wrong");
endmodule

bind dpll_reference_profile_bank profile_bank_sva #(.ADDR_W(ADDR_W)) u_sva (.clk(clk),
    .nrst(nrst), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .refActive(refActive), .profile(profile), .derived(derived));

// file: tb/dpll_reference_profile_bank_bench.sv
// Self-checking bench for the reference profile register bank.
// Drives the Avalon-MM slave port and refActive directly.
`timescale 1ns/1ps
module dpll_reference_profile_bank_bench;
    logic                       clk, nrst, read, write, refActive, waitrequest;
    logic [12:0]                address;
    logic [31:0]                writedata, readdata, q;
    logic [3:0]                 byteenable;
    profile_bank_pkg::profile_s profile, expP;
    profile_bank_pkg::derived_s derived;
    int                         n_mismatch, tests_run, cyc;

    dpll_reference_profile_bank #(.ADDR_W(13)) DUT (.clk(clk), .nrst(nrst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .refActive(refActive),
        .profile(profile), .derived(derived));

    // Clock source
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // Cycle ceiling against a hung handshake
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic close_out();
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [511:0] s, input logic [511:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    // One access, held until waitrequest is seen low, then one idle edge
    task automatic acc(input logic [10:0] i, input logic w, input logic [7:0] d, input logic be);
        address <= {i, 2'h0};
        read <= !w;
        write <= w;
        writedata <= {24'h0, d};
        byteenable <= {3'h0, be};
        do @(posedge clk); while (waitrequest !== 1'h0);
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rdc(input logic [10:0] i, input logic [7:0] e);
        acc(i, 1'h0, 8'h00, 1'h1);
        chk($sformatf("reg %h", i), q, {24'h0, e});
    endtask

    // Writable bits of each byte; zero past the last used byte
    function automatic logic [7:0] msk(input logic [10:0] i);
        case (i)
            11'h632: return 8'hbf;
            11'h639: return 8'h03;
            11'h63c, 11'h63f: return 8'h0f;
            11'h649: return 8'h7f;
            11'h64c, 11'h653, 11'h657, 11'h65a: return 8'h3f;
            11'h659: return 8'hf3;
            default: return (i > 11'h663) ? 8'h00 : 8'hff;
        endcase
    endfunction

    // Main sequence
    initial begin
        {nrst, read, write, refActive, address, writedata, byteenable} = '0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        for (int i = 11'h632; i <= 11'h67f; i++) begin
            acc(11'(i), 1'h1, 8'hff, 1'h1);
            rdc(11'(i), msk(11'(i)));
        end
        for (int i = 11'h632; i <= 11'h663; i++)
            acc(11'(i), 1'h1, 8'(i), 1'h1);
        expP = '{selPriority: 3'h2, promotedPriority: 3'h6, phaseScaleNs: 1'h0,
            refPeriodFs: 50'h1_3837_3635_3433, innerTolerance: 20'hc3b3a,
            outerTolerance: 20'hf3e3d, validationMs: 16'h4140, redetectMs: 16'h4342,
            alphaLinear: 16'h4544, alphaExp1: 6'h06, alphaExp2: 3'h5, alphaExp3: 4'h4,
            betaLinear: 17'h0a423, betaExp: 5'h12, gammaLinear: 17'h04b4a, gammaExp: 5'h06,
            deltaLinear: 15'h4e4d, deltaExp: 5'h1e, inDivide: 30'h13525150,
            fbInteger: 30'h17565554, fbFracV: 10'h158, fbFracU: 10'h1a5,
            phaseThreshold: 16'h5c5b, phaseFill: 8'h5d, phaseDrain: 8'h5e,
            freqThresholdPs: 24'h61605f, freqFill: 8'h62, freqDrain: 8'h63};
        repeat (2) @(posedge clk);
        chk("profile", profile, expP);
        chk("ratios", {derived.inDivideRatio, derived.fbDivideRatio}, 62'h9a928a897565555);
        chk("eff prio", derived.effPriority, 3'h2);
        chk("thr ps", derived.phaseThresholdPs, 26'h5c5b);
        refActive <= 1'h1;
        repeat (2) @(posedge clk);
        chk("eff prio", derived.effPriority, 3'h6);
        rdc(11'h700, 8'h05);
        // Scale bit set: threshold counts nanoseconds
        acc(11'h632, 1'h1, 8'hb2, 1'h1);
        repeat (2) @(posedge clk);
        chk("thr ns", derived.phaseThresholdPs, 26'h5c5b * 26'h3e8);
        // Disabled byte lane leaves the register alone
        acc(11'h65d, 1'h1, 8'h00, 1'h0);
        rdc(11'h65d, 8'h5d);
        // Feedback integer of six, below its floor
        for (int i = 11'h655; i <= 11'h657; i++)
            acc(11'(i), 1'h1, 8'h00, 1'h1);
        acc(11'h654, 1'h1, 8'h06, 1'h1);
        rdc(11'h700, 8'h07);
        repeat (2) @(posedge clk);
        chk("fb ratio", derived.fbDivideRatio, 31'h7);
        // Reset in mid-run clears every setting
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        chk("reset", profile, '0);
        chk("reset ratio", derived.fbDivideRatio, 31'h1);
        // Bus answers again straight after the release
        rdc(11'h654, 8'h00);
        close_out();
    end
endmodule
